// ---- design/lldsb_top.sv ----
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`include "lldsb_defs.svh"
// Notes on behaviour
// - Idle status output while link inactive
// - Initialising output while in init state
// - Running output while in active state
// - Ready only when active and passing packets
// - Sent pulse once DLLP actually transmitted
// - Received PM type uses same encoding
// - Received vendor payload on output
// - Valid strobe qualifies received type, payload
// - Flag replay buffer empty
// - Flag DLLP waiting for transmission
// - Pulse on each packet received while link active
module lldsb_top (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic irq, // Level interrupt
  input wire lldsb_pkg::lldsb_txreq_t tx_req, // User send request
  input wire lldsb_pkg::lldsb_rxmsg_t rx_dllp, // DLLP from receive path
  input wire logic rx_tlp, // Packet decoded from receive path
  input wire logic replay_pending, // Replay buffer holds packets
  output lldsb_pkg::lldsb_txreq_t tx_phy, // DLLP handed to link
  output logic link_layer_idle_state, // Inactive state
  output logic link_layer_initialising, // Init state
  output logic link_layer_running, // Active state
  output logic link_layer_ready, // Active and delivering
  output logic dllp_sent, // One-cycle sent pulse
  output lldsb_pkg::lldsb_rxmsg_t rx_msg, // Received DLLP report
  output logic replay_empty, // Replay buffer empty
  output logic dllp_pending, // DLLP waiting to send
  output logic tlp_received // One-cycle receive pulse
);
  import lldsb_pkg::*;

  localparam int INIT_CYC = `LLDSB_INIT_CYC;
  localparam int TX_CYC = `LLDSB_TX_CYC;

  // Register state
  logic [1:0] ctrl, next_ctrl; // Link enable and trained bits
  logic [2:0] irq_stat, next_irq_stat; // Sticky events
  logic [2:0] irq_mask, next_irq_mask; // Interrupt mask
  logic [31:0] next_prdata; // Read mux
  logic next_pready; // Access ack
  logic next_pslverr; // Unmapped flag
  logic next_irq; // Interrupt level
  // Link layer state
  lldsb_state_t state, next_state; // Current link state
  logic [7:0] init_cnt, next_init_cnt; // Init dwell counter
  // Transmit state
  logic busy, next_busy; // DLLP queued
  logic [3:0] tx_cnt, next_tx_cnt; // Transmit latency counter
  lldsb_txreq_t next_tx_phy; // Latched DLLP
  logic next_sent; // Sent pulse
  logic sent_seen, next_sent_seen; // Wait for command release
  // Receive outputs
  lldsb_rxmsg_t next_rx_msg; // Next receive report
  logic next_tlp_rcvd; // Next packet pulse
  logic [31:0] act_cnt, next_act_cnt; // Received packet count
  logic wr_en; // APB write strobe
  logic rd_en; // APB setup strobe

  // Refuse timing counts that the 8-bit and 4-bit counters cannot hold
  if (INIT_CYC < 1 || INIT_CYC > 255 || TX_CYC < 1 || TX_CYC > 15) begin : g_bad_timing
    $error("lldsb_top: timing constants out of range");
  end

  // Write lands at the access edge where pready is seen high
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable;

  // Link layer state machine
  always_comb begin
    next_state = state;
    next_init_cnt = init_cnt;
    case (state)
      LLDSB_INACTIVE: begin
        next_init_cnt = 8'h00;
        if (ctrl[`LLDSB_CTRL_LINK_EN]) begin
          next_state = LLDSB_INIT;
        end
      end
      LLDSB_INIT: begin
        if (!ctrl[`LLDSB_CTRL_LINK_EN]) begin
          next_state = LLDSB_INACTIVE;
        end else if (init_cnt == 8'(INIT_CYC - 1)) begin
          next_state = LLDSB_ACTIVE;
        end else begin
          next_init_cnt = init_cnt + 8'h01;
        end
      end
      LLDSB_ACTIVE: begin
        if (!ctrl[`LLDSB_CTRL_LINK_EN]) begin
          next_state = LLDSB_INACTIVE;
        end
      end
      default: next_state = LLDSB_INACTIVE;
    endcase
  end

  // DLLP send path; a request is taken while not busy and after release
  always_comb begin
    next_busy = busy;
    next_tx_cnt = tx_cnt;
    next_tx_phy = tx_phy;
    next_sent = 1'b0;
    next_sent_seen = sent_seen;
    if (tx_req.cmd == `LLDSB_CMD_NONE) begin
      next_sent_seen = 1'b0;
    end
    if (busy) begin
      if (tx_cnt == 4'(TX_CYC - 1)) begin
        next_busy = 1'b0;
        next_sent = 1'b1;
        next_sent_seen = 1'b1;
        next_tx_phy = '0;
      end else begin
        next_tx_cnt = tx_cnt + 4'h1;
      end
    end else if (!sent_seen && state == LLDSB_ACTIVE &&
                 (tx_req.cmd == `LLDSB_CMD_PM || tx_req.cmd == `LLDSB_CMD_VEND)) begin
      next_busy = 1'b1;
      next_tx_cnt = 4'h0;
      next_tx_phy.cmd = tx_req.cmd;
      next_tx_phy.pmtype = tx_req.pmtype;
      next_tx_phy.vdata = (tx_req.cmd == `LLDSB_CMD_VEND) ? tx_req.vdata : 24'h000000;
    end
  end

  // Receive reporting, gated by active link
  always_comb begin
    next_rx_msg = '0;
    next_tlp_rcvd = 1'b0;
    if (state == LLDSB_ACTIVE && rx_dllp.valid) begin
      next_rx_msg = rx_dllp;
    end
    if (state == LLDSB_ACTIVE && rx_tlp) begin
      next_tlp_rcvd = 1'b1;
    end
  end

  // Registers, interrupt and APB answer
  always_comb begin
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_act_cnt = act_cnt + (next_tlp_rcvd ? 32'h1 : 32'h0);
    next_pready = psel && !pready;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (wr_en) begin
      case (paddr)
        `LLDSB_OFF_CTRL: next_ctrl = pwdata[1:0];
        `LLDSB_OFF_IRQ_STAT: next_irq_stat = irq_stat & ~pwdata[2:0];
        `LLDSB_OFF_IRQ_MASK: next_irq_mask = pwdata[2:0];
        `LLDSB_OFF_STATUS, `LLDSB_OFF_RX_INFO, `LLDSB_OFF_ACT: ;
        default: ;
      endcase
    end
    if (rd_en) begin
      case (paddr)
        `LLDSB_OFF_CTRL: next_prdata = {30'h0, ctrl};
        `LLDSB_OFF_STATUS: next_prdata = {26'h0, dllp_pending, replay_empty, link_layer_ready,
                                          link_layer_running, link_layer_initialising,
                                          link_layer_idle_state};
        `LLDSB_OFF_IRQ_STAT: next_prdata = {29'h0, irq_stat};
        `LLDSB_OFF_IRQ_MASK: next_prdata = {29'h0, irq_mask};
        `LLDSB_OFF_RX_INFO: next_prdata = {5'h0, rx_msg.pmtype, rx_msg.vdata};
        `LLDSB_OFF_ACT: next_prdata = act_cnt;
        default: next_prdata = 32'h0;
      endcase
      // Decoded in setup so the error stands when pready is sampled
      next_pslverr = !(paddr inside {`LLDSB_OFF_CTRL, `LLDSB_OFF_STATUS, `LLDSB_OFF_IRQ_STAT,
                                     `LLDSB_OFF_IRQ_MASK, `LLDSB_OFF_RX_INFO, `LLDSB_OFF_ACT});
    end
    // Hardware set wins over software clear
    if (next_sent) next_irq_stat[`LLDSB_IRQ_SENT] = 1'b1;
    if (next_rx_msg.valid) next_irq_stat[`LLDSB_IRQ_RXMSG] = 1'b1;
    if (next_state == LLDSB_ACTIVE && state != LLDSB_ACTIVE) next_irq_stat[`LLDSB_IRQ_UP] = 1'b1;
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= LLDSB_INACTIVE;
      init_cnt <= 8'h00;
      busy <= 1'b0;
      tx_cnt <= 4'h0;
      tx_phy <= '0;
      sent_seen <= 1'b0;
      dllp_sent <= 1'b0;
      rx_msg <= '0;
      tlp_received <= 1'b0;
      act_cnt <= 32'h0;
      ctrl <= `LLDSB_CTRL_RST;
      irq_stat <= 3'h0;
      irq_mask <= `LLDSB_MASK_RST;
      irq <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      link_layer_idle_state <= 1'b1;
      link_layer_initialising <= 1'b0;
      link_layer_running <= 1'b0;
      link_layer_ready <= 1'b0;
      replay_empty <= 1'b1;
      dllp_pending <= 1'b0;
    end else begin
      state <= next_state;
      init_cnt <= next_init_cnt;
      busy <= next_busy;
      tx_cnt <= next_tx_cnt;
      tx_phy <= next_tx_phy;
      sent_seen <= next_sent_seen;
      dllp_sent <= next_sent;
      rx_msg <= next_rx_msg;
      tlp_received <= next_tlp_rcvd;
      act_cnt <= next_act_cnt;
      ctrl <= next_ctrl;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      link_layer_idle_state <= (next_state == LLDSB_INACTIVE);
      link_layer_initialising <= (next_state == LLDSB_INIT);
      link_layer_running <= (next_state == LLDSB_ACTIVE);
      link_layer_ready <= (next_state == LLDSB_ACTIVE) && next_ctrl[`LLDSB_CTRL_TRAINED];
      replay_empty <= !replay_pending;
      dllp_pending <= next_busy;
    end
  end

  // Assertions
  property p_idle;
    @(posedge pclk) disable iff (!presetn) link_layer_idle_state == (state == LLDSB_INACTIVE);
  endproperty
  a_idle: assert property (p_idle) else $error("idle flag wrong");
  property p_init;
    @(posedge pclk) disable iff (!presetn) link_layer_initialising == (state == LLDSB_INIT);
  endproperty
  a_init: assert property (p_init) else $error("init flag wrong");
  property p_run;
    @(posedge pclk) disable iff (!presetn) link_layer_running == (state == LLDSB_ACTIVE);
  endproperty
  a_run: assert property (p_run) else $error("running flag wrong");
  property p_ready;
    @(posedge pclk) disable iff (!presetn) link_layer_ready |-> link_layer_running;
  endproperty
  a_ready: assert property (p_ready) else $error("ready without active");
  property p_ready_trn;
    @(posedge pclk) disable iff (!presetn)
      link_layer_ready == (link_layer_running && ctrl[`LLDSB_CTRL_TRAINED]);
  endproperty
  a_ready_trn: assert property (p_ready_trn) else $error("ready ignores trained bit");
  sequence s_take;
    !busy ##1 busy;
  endsequence
  property p_sent;
    @(posedge pclk) disable iff (!presetn) s_take |-> ##4 dllp_sent ##1 !dllp_sent;
  endproperty
  a_sent: assert property (p_sent) else $error("sent pulse timing");
  property p_sent_once;
    @(posedge pclk) disable iff (!presetn) dllp_sent |=> !dllp_sent;
  endproperty
  a_sent_once: assert property (p_sent_once) else $error("sent pulse too long");
  property p_rx;
    @(posedge pclk) disable iff (!presetn)
      (rx_dllp.valid && state == LLDSB_ACTIVE) |=> (rx_msg == $past(rx_dllp));
  endproperty
  a_rx: assert property (p_rx) else $error("rx report mismatch");
  property p_pend;
    @(posedge pclk) disable iff (!presetn)
      $rose(dllp_pending) |-> ($past(tx_req.cmd) inside {`LLDSB_CMD_PM, `LLDSB_CMD_VEND});
  endproperty
  a_pend: assert property (p_pend) else $error("pending flag wrong");
  property p_tlp;
    @(posedge pclk) disable iff (!presetn) (rx_tlp && state == LLDSB_ACTIVE) |=> tlp_received;
  endproperty
  a_tlp: assert property (p_tlp) else $error("packet pulse missing");
  property p_empty;
    @(posedge pclk) disable iff (!presetn) replay_pending |=> !replay_empty;
  endproperty
  a_empty: assert property (p_empty) else $error("replay empty wrong");
  property p_drained;
    @(posedge pclk) disable iff (!presetn) !replay_pending |=> replay_empty;
  endproperty
  a_drained: assert property (p_drained) else $error("replay empty missing");
  // Offsets at or above 0x020 are unmapped and must answer with an error
  property p_slverr;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && paddr[11:5] != 7'h00) |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access without error");
endmodule

// ---- shared/lldsb_defs.svh ----
`ifndef LLDSB_DEFS_SVH
`define LLDSB_DEFS_SVH
// Register byte offsets
`define LLDSB_OFF_CTRL 12'h000
`define LLDSB_OFF_STATUS 12'h004
`define LLDSB_OFF_IRQ_STAT 12'h008
`define LLDSB_OFF_IRQ_MASK 12'h00c
`define LLDSB_OFF_RX_INFO 12'h010
`define LLDSB_OFF_ACT 12'h014
// Control fields
`define LLDSB_CTRL_LINK_EN 0
`define LLDSB_CTRL_TRAINED 1
// Interrupt bit positions
`define LLDSB_IRQ_SENT 0
`define LLDSB_IRQ_RXMSG 1
`define LLDSB_IRQ_UP 2
// Reset values
`define LLDSB_CTRL_RST 2'h0
`define LLDSB_MASK_RST 3'h0
// Timing: init state holds for this many ns
`define LLDSB_INIT_NS 160
`define LLDSB_CLK_NS 20
`define LLDSB_INIT_CYC ((`LLDSB_INIT_NS + `LLDSB_CLK_NS - 1) / `LLDSB_CLK_NS)
// Transmit latency of a queued DLLP in cycles
`define LLDSB_TX_CYC 4
// Send command codes
`define LLDSB_CMD_NONE 2'h0
`define LLDSB_CMD_PM 2'h1
`define LLDSB_CMD_VEND 2'h2
`endif

// ---- shared/lldsb_pkg.sv ----
package lldsb_pkg;
  // Link layer states
  typedef enum logic [1:0] {
    LLDSB_INACTIVE = 2'b00,
    LLDSB_INIT = 2'b01,
    LLDSB_ACTIVE = 2'b10
  } lldsb_state_t;
  // Power-management type codes
  typedef enum logic [2:0] {
    LLDSB_PM_L1 = 3'b000,
    LLDSB_PM_L2 = 3'b001,
    LLDSB_PM_ASL1 = 3'b011,
    LLDSB_PM_ACK = 3'b100
  } lldsb_pm_t;
  // Send request from user logic
  typedef struct packed {
    logic [1:0] cmd;
    logic [2:0] pmtype;
    logic [23:0] vdata;
  } lldsb_txreq_t;
  // Received DLLP report
  typedef struct packed {
    logic valid;
    logic [2:0] pmtype;
    logic [23:0] vdata;
  } lldsb_rxmsg_t;
endpackage

// ---- sim/lldsb_user_pm.sv ----
`timescale 1ns/1ps
// User power-management logic: one send at a time, held until acknowledged
module lldsb_user_pm (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic go, // Start one request
  input wire lldsb_pkg::lldsb_txreq_t req, // Request to issue
  input wire logic dllp_sent, // Send acknowledge
  output lldsb_pkg::lldsb_txreq_t tx_req // Request to device
);
  import lldsb_pkg::*;
  lldsb_txreq_t next_tx_req; // Next request value
  // Take a new request, or return the command to idle once sent
  always_comb begin
    next_tx_req = tx_req;
    if (go) begin
      next_tx_req = req;
    end else if (dllp_sent) begin
      next_tx_req.cmd = 2'h0;
    end
  end
  // Register the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_req <= '0;
    end else begin
      tx_req <= next_tx_req;
    end
  end
endmodule

// ---- sim/lldsb_top_tb_top.sv ----
`timescale 1ns/1ps
`include "lldsb_defs.svh"
module lldsb_top_tb_top;
  import lldsb_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_b;
  logic go, rx_tlp, replay_pending, dllp_sent, replay_empty, dllp_pending, tlp_received;
  logic link_layer_idle_state, link_layer_initialising, link_layer_running, link_layer_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  lldsb_txreq_t req, tx_req, tx_phy;
  lldsb_rxmsg_t rx_dllp, rx_msg;
  logic [2:0] pm [4] = '{LLDSB_PM_L1, LLDSB_PM_L2, LLDSB_PM_ASL1, LLDSB_PM_ACK};
  int errors, tests_run, cyc, n;
  lldsb_top u_lldsb_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .tx_req, .rx_dllp, .rx_tlp, .replay_pending, .tx_phy,
    .link_layer_idle_state, .link_layer_initialising, .link_layer_running,
    .link_layer_ready, .dllp_sent, .rx_msg, .replay_empty, .dllp_pending, .tlp_received);
  lldsb_user_pm u_lldsb_user_pm (.pclk, .presetn, .go, .req, .dllp_sent, .tx_req);
  // Clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // APB transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err_b = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // One send through the user model, checked to its acknowledge
  task automatic send(input logic [1:0] c, input logic [2:0] t, input logic [23:0] v);
    req <= {c, t, v};
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    while (dllp_pending !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(tx_phy), 32'({c, t, v}));
    n = 0;
    while (dllp_sent !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(n, `LLDSB_TX_CYC);
    @(posedge pclk);
    chk({dllp_sent, dllp_pending}, 0);
    tick(2);
  endtask
  task automatic stop_test();
    $display("Errors %0d, comparisons %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, go, rx_tlp, replay_pending} = '0;
    {paddr, pwdata, req, rx_dllp} = '0;
    {errors, tests_run, cyc} = '0;
    tick(6);
    presetn <= 1'b1;
    tick(1);
    apb(0, `LLDSB_OFF_STATUS, 0);
    chk(rd, 32'h11);
    apb(1, `LLDSB_OFF_CTRL, 32'h3);
    tick(1);
    chk(link_layer_initialising, 1);
    n = 0;
    while (link_layer_running !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    tick(2);
    apb(0, `LLDSB_OFF_STATUS, 0);
    chk(rd, 32'h1c);
    apb(0, `LLDSB_OFF_IRQ_STAT, 0);
    chk(rd, 32'h4);
    chk(irq, 0);
    apb(1, `LLDSB_OFF_IRQ_MASK, 32'h4);
    tick(1);
    chk(irq, 1);
    apb(1, `LLDSB_OFF_IRQ_STAT, 32'h4);
    tick(1);
    chk(irq, 0);
    apb(0, 12'h020, 0);
    chk({31'h0, err_b}, 32'h1);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) send(`LLDSB_CMD_PM, pm[i], 24'h0);
    send(`LLDSB_CMD_VEND, 3'h0, 24'ha5c3f1);
    req <= {2'h3, 3'h0, 24'h0};
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(8);
    chk({dllp_pending, dllp_sent}, 0);
    req <= '0;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rx_dllp <= {1'b1, pm[i], 24'h5a3c96 ^ 24'(i)};
      tick(1);
      rx_dllp <= '0;
      tick(1);
      chk(32'(rx_msg), 32'({1'b1, pm[i], 24'h5a3c96 ^ 24'(i)}));
      tick(1);
      chk(rx_msg.valid, 0);
    end
    rx_tlp <= 1'b1;
    tick(1);
    rx_tlp <= 1'b0;
    tick(1);
    chk(tlp_received, 1);
    tick(1);
    chk(tlp_received, 0);
    replay_pending <= 1'b1;
    tick(3);
    chk(replay_empty, 0);
    replay_pending <= 1'b0;
    tick(3);
    chk(replay_empty, 1);
    apb(1, `LLDSB_OFF_CTRL, 32'h1);
    tick(1);
    chk({link_layer_running, link_layer_ready}, 2'b10);
    apb(1, `LLDSB_OFF_CTRL, 32'h0);
    tick(2);
    chk({link_layer_idle_state, link_layer_running, link_layer_ready}, 3'b100);
    stop_test();
  end
endmodule
